//--- inc/ccst_pkg.sv
package ccst_pkg;

  // Status byte bit positions
  localparam int SB_BUSY = 0;
  localparam int SB_LIST = 1;
  localparam int SB_ERRQ = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV  = 4;
  localparam int SB_ESB  = 5;
  localparam int SB_MSS  = 6;
  localparam int SB_OPER = 7;

  localparam logic [7:0] SRE_RESET      = 8'h00;
  localparam logic [7:0] SRE_RW_MASK    = 8'hbf;
  localparam logic [7:0] TST_BASIC_MASK = 8'h17;
  localparam logic [7:0] TST_EXT_MASK   = 8'hf7;
  localparam logic [7:0] RESP_RESET     = 8'h00;

  // Option flag positions in the options answer
  localparam int OPT_LIMIT_CAL  = 0;
  localparam int OPT_BUS_REMOTE = 1;
  localparam int OPT_COMP_LOCS  = 2;
  localparam int OPT_PROT_STEP  = 3;
  localparam int OPT_SEQ_APPLY  = 4;

  localparam int ARG_W = 16;
  localparam int SLOTS = 99;
  localparam logic [ARG_W-1:0] SLOT_MIN   = 16'h0001;
  localparam logic [ARG_W-1:0] SLOT_MAX   = 16'h0063;
  localparam logic [ARG_W-1:0] LEVEL_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    FN_VOLT = 2'b00,
    FN_CURR = 2'b01,
    FN_EXT  = 2'b10
  } ccst_func_e;

  typedef enum logic [0:0] {
    SRC_BUS = 1'b0,
    SRC_IMM = 1'b1
  } ccst_src_e;

  typedef enum logic [4:0] {
    CMD_NOP       = 5'h00,
    CMD_SRE_SET   = 5'h01,
    CMD_SRE_QRY   = 5'h02,
    CMD_STB_QRY   = 5'h03,
    CMD_SPOLL     = 5'h04,
    CMD_TRG       = 5'h05,
    CMD_GET       = 5'h06,
    CMD_INIT      = 5'h07,
    CMD_INIT_CONT = 5'h08,
    CMD_TST_QRY   = 5'h09,
    CMD_DIAG_QRY  = 5'h0a,
    CMD_RST       = 5'h0b,
    CMD_SAV       = 5'h0c,
    CMD_RCL       = 5'h0d,
    CMD_WAI       = 5'h0e,
    CMD_OPT_QRY   = 5'h0f,
    CMD_VOLT      = 5'h10,
    CMD_CURR      = 5'h11,
    CMD_VOLT_TRIG = 5'h12,
    CMD_CURR_TRIG = 5'h13,
    CMD_FUNC      = 5'h14,
    CMD_OUTP      = 5'h15,
    CMD_TRIG_SRC  = 5'h16,
    CMD_MAIN_MODE = 5'h17,
    CMD_PROT_MODE = 5'h18,
    CMD_VOLT_PROT = 5'h19,
    CMD_CURR_PROT = 5'h1a
  } ccst_cmd_e;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_WAIT   = 2'b01,
    ST_RECALL = 2'b10
  } ccst_state_e;

  typedef struct packed {
    ccst_cmd_e        code;
    logic [ARG_W-1:0] arg;
  } ccst_cmd_s;

  typedef struct packed {
    logic oper;
    logic esb;
    logic mav;
    logic ques;
    logic error_queue_nonempty;
    logic list_run;
    logic busy;
  } ccst_stat_s;

  typedef struct packed {
    ccst_func_e       func;
    logic             main_ext;
    logic             prot_ext;
    logic [ARG_W-1:0] volt;
    logic [ARG_W-1:0] curr;
    logic [ARG_W-1:0] volt_prot;
    logic [ARG_W-1:0] curr_prot;
    logic             out_on;
  } ccst_set_s;

  function automatic logic slot_ok(input logic [ARG_W-1:0] a);
    return (a >= SLOT_MIN) && (a <= SLOT_MAX);
  endfunction

endpackage

//--- rtl/ccst_mem.sv
`timescale 1ns/1ps
module ccst_mem #(
  parameter int DEPTH = ccst_pkg::SLOTS
) (
  input  wire logic                clk_sys_in,   // System clock
  input  wire logic                rst_in,       // Async reset, high
  input  wire logic                wr_en_in,     // Store settings
  input  wire logic                rd_en_in,     // Fetch settings
  input  wire logic [6:0]          slot_in,      // Slot number, 1 based
  input  wire ccst_pkg::ccst_set_s wr_data_in,   // Settings to store
  output ccst_pkg::ccst_set_s      rd_data_out,  // Fetched settings
  output logic                     rd_valid_out  // Fetch done pulse
);
  import ccst_pkg::*;

  ccst_set_s  mem [DEPTH];
  logic [6:0] idx;

  assign idx = slot_in - SLOT_MIN[6:0];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[idx] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= mem[idx];
      end
    end
  end

endmodule

//--- rtl/ccst_top.sv
`timescale 1ns/1ps
module ccst_top #(
  parameter logic [15:0] PROT_BOX  = 16'hffff,
  parameter logic [7:0]  OPT_FLAGS = 8'h1f
) (
  input  wire logic                 clk_sys_in,       // System clock
  input  wire logic                 rst_in,           // Async reset, high
  input  wire logic                 cmd_valid_in,     // Command offered
  input  wire ccst_pkg::ccst_cmd_s  cmd_in,           // Code and argument
  input  wire logic                 listener_in,      // Addressed listener
  input  wire ccst_pkg::ccst_stat_s stat_in,          // Status causes
  input  wire logic [7:0]           st_fail_in,       // Subtest failures
  input  wire logic                 rst_output_on_in, // Output after reset
  output logic                      cmd_ready_out,    // Command taken
  output logic                      resp_valid_out,   // Answer pulse
  output logic [7:0]                resp_data_out,    // Answer byte
  output logic                      srq_out,          // Service request
  output logic [7:0]                status_byte_out,  // Status byte
  output ccst_pkg::ccst_set_s       settings_out,     // Output settings
  output logic [15:0]               volt_trig_out,    // Triggered voltage
  output logic [15:0]               curr_trig_out,    // Triggered current
  output logic                      wait_trig_out,    // Oper cond bit 5
  output logic                      init_cont_out,    // Continuous arm
  output ccst_pkg::ccst_src_e       trig_src_out,     // Trigger source
  output logic                      trig_pulse_out,   // Trigger fired
  output logic                      list_stop_out     // Stop list pulse
);
  import ccst_pkg::*;

  ccst_state_e state;
  ccst_state_e next_state;
  logic [7:0]  service_request_mask;
  logic        rqs;
  logic [7:0]  raw_byte;
  logic        mss_now;
  logic        accept;
  logic        fire;
  logic        is_qry;
  logic        sav_go;
  logic        rcl_go;
  ccst_set_s   rd_data;
  logic        rd_valid;
  ccst_cmd_e   code;
  logic [15:0] arg;

  assign code   = cmd_in.code;
  assign arg    = cmd_in.arg;
  assign accept = cmd_valid_in && cmd_ready_out && (state == ST_RUN);
  assign is_qry = code inside {CMD_SRE_QRY, CMD_STB_QRY, CMD_SPOLL,
                               CMD_TST_QRY, CMD_DIAG_QRY, CMD_OPT_QRY};

  // Summary is recomputed every cycle from live causes
  always_comb begin
    raw_byte          = 8'h00;
    raw_byte[SB_OPER] = stat_in.oper;
    raw_byte[SB_ESB]  = stat_in.esb;
    raw_byte[SB_MAV]  = stat_in.mav;
    raw_byte[SB_QUES] = stat_in.ques;
    raw_byte[SB_ERRQ] = stat_in.error_queue_nonempty;
    raw_byte[SB_LIST] = stat_in.list_run;
    raw_byte[SB_BUSY] = stat_in.busy;
    mss_now = |(raw_byte & service_request_mask & SRE_RW_MASK);
    raw_byte[SB_MSS]  = mss_now;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      status_byte_out <= 8'h00;
    end else begin
      status_byte_out <= raw_byte;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      service_request_mask <= SRE_RESET;
    end else if (accept && code == CMD_SRE_SET) begin
      service_request_mask <= arg[7:0] & SRE_RW_MASK;
    end
  end

  // New reason for service sets the request; the set wins over a poll
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rqs <= 1'b0;
    end else if (mss_now && !status_byte_out[SB_MSS]) begin
      rqs <= 1'b1;
    end else if (accept && code == CMD_SPOLL) begin
      rqs <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      srq_out <= 1'b0;
    end else begin
      srq_out <= rqs;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_data_out  <= RESP_RESET;
    end else begin
      resp_valid_out <= accept && is_qry;
      if (accept) begin
        unique case (code)
          CMD_SRE_QRY: resp_data_out <= service_request_mask;
          CMD_STB_QRY: resp_data_out <= status_byte_out;
          CMD_SPOLL: resp_data_out <= {status_byte_out[SB_OPER], rqs,
            status_byte_out[SB_ESB:SB_BUSY]};
          CMD_TST_QRY: resp_data_out <= st_fail_in & TST_BASIC_MASK;
          CMD_DIAG_QRY: resp_data_out <= st_fail_in & TST_EXT_MASK;
          CMD_OPT_QRY: resp_data_out <= OPT_FLAGS;
          default: begin
          end
        endcase
      end
    end
  end

  // Bus trigger qualification
  assign fire = accept && (code == CMD_TRG || code == CMD_GET)
             && listener_in
             && wait_trig_out
             && (trig_src_out == SRC_BUS)
             && settings_out.out_on;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wait_trig_out <= 1'b0;
      init_cont_out <= 1'b0;
      trig_src_out  <= SRC_BUS;
    end else if (accept && code == CMD_RST) begin
      wait_trig_out <= 1'b0;
      init_cont_out <= 1'b0;
      trig_src_out  <= SRC_BUS;
    end else if (fire) begin
      wait_trig_out <= init_cont_out;
    end else if (accept && code == CMD_INIT_CONT) begin
      init_cont_out <= arg[0];
      if (arg[0]) begin
        wait_trig_out <= 1'b1;
      end
    end else if (accept && code == CMD_INIT && !init_cont_out) begin
      wait_trig_out <= 1'b1;
    end else if (accept && code == CMD_TRIG_SRC) begin
      trig_src_out <= ccst_src_e'(arg[0]);
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      trig_pulse_out <= 1'b0;
      list_stop_out  <= 1'b0;
    end else begin
      trig_pulse_out <= fire;
      list_stop_out  <= accept && code == CMD_RST;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      volt_trig_out <= LEVEL_ZERO;
      curr_trig_out <= LEVEL_ZERO;
    end else if (accept && code == CMD_RST) begin
      volt_trig_out <= LEVEL_ZERO;
      curr_trig_out <= LEVEL_ZERO;
    end else if (accept && code == CMD_VOLT_TRIG) begin
      volt_trig_out <= arg;
    end else if (accept && code == CMD_CURR_TRIG) begin
      curr_trig_out <= arg;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      settings_out           <= '0;
      settings_out.func      <= FN_VOLT;
      settings_out.volt_prot <= PROT_BOX;
      settings_out.curr_prot <= PROT_BOX;
    end else if (accept && code == CMD_RST) begin
      settings_out.func      <= FN_VOLT;
      settings_out.main_ext  <= 1'b0;
      settings_out.prot_ext  <= 1'b0;
      settings_out.volt      <= LEVEL_ZERO;
      settings_out.curr      <= LEVEL_ZERO;
      settings_out.volt_prot <= PROT_BOX;
      settings_out.curr_prot <= PROT_BOX;
      settings_out.out_on    <= rst_output_on_in;
    end else if (rd_valid) begin
      settings_out <= rd_data;
    end else if (fire) begin
      settings_out.volt <= volt_trig_out;
      settings_out.curr <= curr_trig_out;
    end else if (accept) begin
      unique case (code)
        CMD_VOLT:      settings_out.volt      <= arg;
        CMD_CURR:      settings_out.curr      <= arg;
        CMD_VOLT_PROT: settings_out.volt_prot <= arg;
        CMD_CURR_PROT: settings_out.curr_prot <= arg;
        CMD_FUNC:      settings_out.func      <= ccst_func_e'(arg[1:0]);
        CMD_OUTP:      settings_out.out_on    <= arg[0];
        CMD_MAIN_MODE: settings_out.main_ext  <= arg[0];
        CMD_PROT_MODE: settings_out.prot_ext  <= arg[0];
        default: begin
        end
      endcase
    end
  end

  assign sav_go = accept && code == CMD_SAV && slot_ok(arg);
  assign rcl_go = accept && code == CMD_RCL && slot_ok(arg);

  ccst_mem u_mem (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .wr_en_in     (sav_go),
    .rd_en_in     (rcl_go),
    .slot_in      (arg[6:0]),
    .wr_data_in   (settings_out),
    .rd_data_out  (rd_data),
    .rd_valid_out (rd_valid)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (accept && code == CMD_WAI && stat_in.busy) begin
          next_state = ST_WAIT;
        end else if (rcl_go) begin
          next_state = ST_RECALL;
        end
      end
      ST_WAIT: begin
        if (!stat_in.busy) begin
          next_state = ST_RUN;
        end
      end
      ST_RECALL: next_state = ST_RUN;
      default:   next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state         <= ST_RUN;
      cmd_ready_out <= 1'b0;
    end else begin
      state         <= next_state;
      cmd_ready_out <= (next_state == ST_RUN);
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_mask_bit6: assert property (
    !service_request_mask[SB_MSS]) else $error("mask bit 6 set");
  a_mask_write: assert property (
    accept && code == CMD_SRE_SET |=>
      service_request_mask == ($past(arg[7:0]) & SRE_RW_MASK))
    else $error("mask write wrong");
  a_mss_or: assert property (
    ##1 status_byte_out[SB_MSS] == |($past(raw_byte) &
      $past(service_request_mask) & SRE_RW_MASK))
    else $error("summary bit not OR of enabled bits");
  a_stb_follows: assert property (
    ##1 (status_byte_out & SRE_RW_MASK) == ($past(raw_byte) & SRE_RW_MASK))
    else $error("status byte not following causes");
  a_stb_query: assert property (
    accept && code == CMD_STB_QRY |=>
      resp_valid_out && resp_data_out == $past(status_byte_out)
      && rqs == $past(rqs || (mss_now && !status_byte_out[SB_MSS])))
    else $error("status query wrong");
  a_spoll_clear: assert property (
    accept && code == CMD_SPOLL && !(mss_now && !status_byte_out[SB_MSS])
      |=> !rqs && resp_data_out[SB_MSS] == $past(rqs))
    else $error("serial poll wrong");
  a_trig_load: assert property (
    fire |=> settings_out.volt == $past(volt_trig_out)
      && settings_out.curr == $past(curr_trig_out)
      && wait_trig_out == $past(init_cont_out) && trig_pulse_out)
    else $error("trigger load wrong");
  a_trig_cause: assert property (
    trig_pulse_out |-> $past(listener_in && wait_trig_out
      && trig_src_out == SRC_BUS && settings_out.out_on))
    else $error("trigger without cause");
  a_single_arm: assert property (
    trig_pulse_out && !$past(init_cont_out) |-> !wait_trig_out)
    else $error("single arm not consumed");
  a_tst_code: assert property (
    accept && code == CMD_TST_QRY |=>
      resp_valid_out && resp_data_out == ($past(st_fail_in) & TST_BASIC_MASK))
    else $error("self test code wrong");
  a_rst_defaults: assert property (
    accept && code == CMD_RST |=> list_stop_out && !init_cont_out
      && settings_out.volt == LEVEL_ZERO && volt_trig_out == LEVEL_ZERO
      && trig_src_out == SRC_BUS && settings_out.func == FN_VOLT
      && settings_out.out_on == $past(rst_output_on_in))
    else $error("reset defaults wrong");
  a_wai_block: assert property (
    state == ST_WAIT |-> !cmd_ready_out) else $error("wait not blocking");
  a_rcl_apply: assert property (
    rcl_go |=> ##1 settings_out == $past(rd_data))
    else $error("recall not applied");

  c_trigger: cover property (fire);
  c_poll_rqs: cover property (accept && code == CMD_SPOLL && rqs);
  c_wait: cover property (state == ST_WAIT ##1 state == ST_RUN);
  c_recall: cover property (rcl_go ##2 cmd_ready_out);

endmodule

//--- tb/ccst_ctl_model.sv
`timescale 1ns/1ps
module ccst_ctl_model (
  input  wire logic           clk_sys_in,    // System clock
  input  wire logic           ready_in,      // Device takes command
  input  wire logic           resp_valid_in, // Answer pulse
  input  wire logic [7:0]     resp_data_in,  // Answer byte
  output logic                cmd_valid_out, // Command offered
  output ccst_pkg::ccst_cmd_s cmd_out        // Code and argument
);
  import ccst_pkg::*;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_out       = '0;
  end

  // Offer on a falling edge and hold until a rising edge sees ready high
  task automatic xfer(input ccst_cmd_e c, input logic [15:0] a,
                      output logic [7:0] d, output logic got);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b1;
    cmd_out       = '{code: c, arg: a};
    while (ready_in !== 1'b1 && n < 100) begin
      @(negedge clk_sys_in);
      n++;
    end
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    // Released lines show a changed pattern, never the old command
    cmd_valid_out = 1'b0;
    cmd_out       = ccst_cmd_s'(~cmd_out);
    got           = resp_valid_in;
    d             = resp_data_in;
  endtask
endmodule

//--- tb/common_cmd_status_trigger_tb.sv
`timescale 1ns/1ps
module common_cmd_status_trigger_tb;
  import ccst_pkg::*;
  localparam logic [15:0] BOX = 16'h1234;
  logic       clk_sys_in, rst_in, cmd_valid, listener, rst_on, got_q;
  logic       cmd_ready_out, resp_valid_out, srq_out, wait_trig_out;
  logic       init_cont_out, trig_pulse_out, list_stop_out;
  logic [7:0] resp_data_out, status_byte_out, st_fail, d_q;
  logic [15:0] volt_trig_out, curr_trig_out;
  ccst_cmd_s  cmd;
  ccst_stat_s stat;
  ccst_set_s  settings_out, es, ea, eb;
  ccst_src_e  trig_src_out;
  int         errors, n_checks;

  ccst_top #(.PROT_BOX(BOX)) uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .listener_in(listener), .stat_in(stat),
    .st_fail_in(st_fail), .rst_output_on_in(rst_on),
    .cmd_ready_out(cmd_ready_out), .resp_valid_out(resp_valid_out),
    .resp_data_out(resp_data_out), .srq_out(srq_out),
    .status_byte_out(status_byte_out), .settings_out(settings_out),
    .volt_trig_out(volt_trig_out), .curr_trig_out(curr_trig_out),
    .wait_trig_out(wait_trig_out), .init_cont_out(init_cont_out),
    .trig_src_out(trig_src_out), .trig_pulse_out(trig_pulse_out),
    .list_stop_out(list_stop_out));

  ccst_ctl_model ctl (
    .clk_sys_in(clk_sys_in), .ready_in(cmd_ready_out),
    .resp_valid_in(resp_valid_out), .resp_data_in(resp_data_out),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk_b(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_y(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_s(input ccst_set_s e);
    n_checks++;
    if (settings_out !== e) begin
      errors++;
      $display("[ERR] settings expected %0h seen %0h", e, settings_out);
    end
  endtask

  task automatic cmd_w(input ccst_cmd_e c, input logic [15:0] a);
    ctl.xfer(c, a, d_q, got_q);
  endtask

  task automatic qry(input ccst_cmd_e c, input logic [15:0] a,
                     input logic [7:0] e);
    ctl.xfer(c, a, d_q, got_q);
    chk_b("resp_valid", 1'b1, got_q);
    chk_y("resp_data", e, d_q);
  endtask

  task automatic trg(input ccst_cmd_e c, input logic e);
    ctl.xfer(c, 16'h0000, d_q, got_q);
    chk_b("trig_pulse", e, trig_pulse_out);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Expected status byte: causes in place, bit 6 set by any enabled cause
  function automatic logic [7:0] sb(input logic [6:0] s,
                                    input logic [7:0] m);
    logic [7:0] b;
    b = {s[6], 1'b0, s[5:0]};
    return ((b & m) != 8'h00) ? (b | 8'h40) : b;
  endfunction

  // Whole run is a few hundred cycles; this limit is 50000 cycles, over a hundred times that
  initial begin
    #500us;
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0; n_checks = 0; rst_in = 1'b1; listener = 1'b1;
    stat = '0; st_fail = 8'h00; rst_on = 1'b0;
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_in = 1'b0;
    es = '0; es.volt_prot = BOX; es.curr_prot = BOX;
    chk_y("status_byte", 8'h00, status_byte_out);
    chk_s(es);
    done("reset");

    cmd_w(CMD_SRE_SET, 16'h00ff);
    qry(CMD_SRE_QRY, 16'h0000, 8'hbf);
    cmd_w(CMD_SRE_SET, 16'h0028);
    qry(CMD_SRE_QRY, 16'h0000, 8'h28);
    for (int i = 0; i < 7; i++) begin
      stat = ccst_stat_s'(7'h01 << i);
      qry(CMD_STB_QRY, 16'h0000, sb(7'h01 << i, 8'h28));
    end
    done("status");

    stat = '0;
    cmd_w(CMD_SPOLL, 16'h0000);
    stat.ques = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk_b("srq", 1'b1, srq_out);
    qry(CMD_SPOLL, 16'h0000, 8'h48);
    qry(CMD_SPOLL, 16'h0000, 8'h08);
    chk_b("srq", 1'b0, srq_out);
    qry(CMD_STB_QRY, 16'h0000, 8'h48);
    qry(CMD_STB_QRY, 16'h0000, 8'h48);
    chk_y("status_byte", 8'h48, status_byte_out);
    stat = '0;
    qry(CMD_STB_QRY, 16'h0000, 8'h00);
    done("poll");

    cmd_w(CMD_OUTP, 16'h0001);
    cmd_w(CMD_TRIG_SRC, 16'h0000);
    cmd_w(CMD_VOLT_TRIG, 16'h0123);
    cmd_w(CMD_CURR_TRIG, 16'h0045);
    trg(CMD_TRG, 1'b0);
    cmd_w(CMD_INIT, 16'h0000);
    chk_b("wait_trig", 1'b1, wait_trig_out);
    listener = 1'b0;
    trg(CMD_TRG, 1'b0);
    trg(CMD_GET, 1'b0);
    listener = 1'b1;
    trg(CMD_GET, 1'b1);
    chk_b("wait_trig", 1'b0, wait_trig_out);
    es.out_on = 1'b1; es.volt = 16'h0123; es.curr = 16'h0045;
    chk_s(es);
    trg(CMD_TRG, 1'b0);
    cmd_w(CMD_INIT_CONT, 16'h0001);
    trg(CMD_TRG, 1'b1);
    @(negedge clk_sys_in);
    chk_b("wait_trig", 1'b1, wait_trig_out);
    trg(CMD_TRG, 1'b1);
    cmd_w(CMD_INIT_CONT, 16'h0000);
    chk_b("init_cont", 1'b0, init_cont_out);
    cmd_w(CMD_TRIG_SRC, 16'h0001);
    trg(CMD_TRG, 1'b0);
    cmd_w(CMD_TRIG_SRC, 16'h0000);
    cmd_w(CMD_OUTP, 16'h0000);
    trg(CMD_TRG, 1'b0);
    done("trigger");

    for (int i = 0; i < 8; i++) begin
      st_fail = 8'h01 << i;
      qry(CMD_TST_QRY, 16'h0000, (8'h01 << i) & 8'h17);
    end
    st_fail = 8'hff;
    qry(CMD_TST_QRY, 16'h0000, 8'h17);
    qry(CMD_DIAG_QRY, 16'h0000, 8'hf7);
    qry(CMD_OPT_QRY, 16'h0000, 8'h1f);
    st_fail = 8'h00;
    qry(CMD_TST_QRY, 16'h0000, 8'h00);
    done("selftest");

    cmd_w(CMD_VOLT, 16'h0077);
    cmd_w(CMD_MAIN_MODE, 16'h0001);
    cmd_w(CMD_PROT_MODE, 16'h0001);
    cmd_w(CMD_FUNC, 16'h0001);
    cmd_w(CMD_TRIG_SRC, 16'h0001);
    rst_on = 1'b1;
    cmd_w(CMD_RST, 16'h0000);
    chk_b("list_stop", 1'b1, list_stop_out);
    es = '0; es.volt_prot = BOX; es.curr_prot = BOX; es.out_on = 1'b1;
    chk_s(es);
    chk_b("init_cont", 1'b0, init_cont_out);
    chk_b("trig_src", SRC_BUS, trig_src_out);
    chk_b("trig_zero", 1'b1, {volt_trig_out, curr_trig_out} === 32'h0);
    rst_on = 1'b0;
    cmd_w(CMD_RST, 16'h0000);
    es.out_on = 1'b0;
    chk_s(es);
    done("reset_cmd");

    cmd_w(CMD_FUNC, 16'h0001);
    cmd_w(CMD_VOLT, 16'h0111);
    cmd_w(CMD_CURR, 16'h0222);
    cmd_w(CMD_MAIN_MODE, 16'h0001);
    cmd_w(CMD_PROT_MODE, 16'h0001);
    cmd_w(CMD_VOLT_PROT, 16'h0333);
    cmd_w(CMD_CURR_PROT, 16'h0666);
    cmd_w(CMD_OUTP, 16'h0001);
    ea = '{func: FN_CURR, main_ext: 1'b1, prot_ext: 1'b1, volt: 16'h0111,
           curr: 16'h0222, volt_prot: 16'h0333, curr_prot: 16'h0666,
           out_on: 1'b1};
    chk_s(ea);
    cmd_w(CMD_SAV, 16'h0001);
    cmd_w(CMD_FUNC, 16'h0000);
    cmd_w(CMD_VOLT, 16'h0444);
    cmd_w(CMD_MAIN_MODE, 16'h0000);
    cmd_w(CMD_OUTP, 16'h0000);
    eb = ea; eb.func = FN_VOLT; eb.volt = 16'h0444;
    eb.main_ext = 1'b0; eb.out_on = 1'b0;
    cmd_w(CMD_SAV, 16'h0063);
    cmd_w(CMD_RCL, 16'h0001);
    cmd_w(CMD_NOP, 16'h0000);
    chk_s(ea);
    cmd_w(CMD_RCL, 16'h0063);
    cmd_w(CMD_NOP, 16'h0000);
    chk_s(eb);
    done("memory");

    stat.busy = 1'b1;
    cmd_w(CMD_WAI, 16'h0000);
    chk_b("cmd_ready", 1'b0, cmd_ready_out);
    repeat (4) @(negedge clk_sys_in);
    chk_b("cmd_ready", 1'b0, cmd_ready_out);
    stat.busy = 1'b0;
    cmd_w(CMD_VOLT, 16'h0555);
    eb.volt = 16'h0555;
    chk_s(eb);
    done("wait");
    end_of_test();
  end
endmodule
